/* cpalu_pkg.sv */
// Shared constants and types of the core ALU block
`default_nettype none
package cpalu_pkg;
    // ==========================================================
    // Register map and status word layout
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_DIVSTAT = 4'h1;
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_OVF = 2;
    localparam int FLG_N = 3;
    localparam int FLG_DCY = 8;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] UPD_ARITH = 16'h010f;
    localparam logic [15:0] UPD_LOGIC = 16'h000a;
    localparam logic [15:0] UPD_SHIFT = 16'h000b;
    localparam logic [15:0] UPD_DIV = 16'h000e;
    localparam logic [15:0] STATUS_WMASK = UPD_ARITH;
    // ==========================================================
    // Divider and shifter constants
    localparam logic [15:0] SIGN16 = 16'h8000;
    localparam logic [4:0] DIV_STEPS = 5'h10;
    localparam logic [4:0] DIV_LAST = DIV_STEPS + 5'h01;
    localparam logic [4:0] DIV_CYCLES = 5'h13;
    localparam logic [3:0] SHIFT_ONE = 4'h1;
    // ==========================================================
    // Operation codes
    typedef enum logic [4:0] {
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBB,
        OP_AND, OP_IOR, OP_XOR,
        OP_SHL, OP_SAR, OP_SHR,
        OP_MUL_SS, OP_MUL_UU, OP_MUL_US, OP_MUL_SL, OP_MUL_UL, OP_MUL_BB,
        OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16
    } cpalu_op_t;
endpackage
`default_nettype wire

/* cpalu_div_if.sv */
// Link between the ALU top and its iterative divider
`default_nettype none
interface cpalu_div_if;
    logic start;
    logic hold;
    logic sgn;
    logic [31:0] dividend;
    logic [15:0] divisor;
    logic busy;
    logic done;
    logic ovf;
    logic [15:0] quot;
    logic [15:0] rmd;
    modport ctl (output start, hold, sgn, dividend, divisor,
                 input busy, done, ovf, quot, rmd);
    modport eng (input start, hold, sgn, dividend, divisor,
                 output busy, done, ovf, quot, rmd);
endinterface
`default_nettype wire

/* cpalu_div.sv */
// Iterative signed and unsigned divider, one quotient bit per cycle
`default_nettype none
module cpalu_div import cpalu_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    cpalu_div_if.eng dv
);
    logic busy_q, done_q, negq_q, negr_q, ovf_q, sgn_q;
    logic [4:0] cnt_q;
    logic [15:0] part_q, shf_q, dvs_q, quot_q, rmd_q, dmag;
    logic [31:0] mag, dvd_q;
    logic [16:0] trial, diff;

    // ==========================================================
    // Magnitudes, sign fixed up after the last step
    assign mag = (dv.sgn && dv.dividend[31]) ? -dv.dividend : dv.dividend;
    assign dmag = (dv.sgn && dv.divisor[15]) ? -dv.divisor : dv.divisor;
    assign trial = {part_q, shf_q[15]};
    assign diff = trial - {1'b0, dvs_q};

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            negq_q <= 1'b0;
            negr_q <= 1'b0;
            ovf_q <= 1'b0;
            sgn_q <= 1'b0;
            cnt_q <= 5'h00;
            part_q <= 16'h0000;
            shf_q <= 16'h0000;
            dvs_q <= 16'h0000;
            quot_q <= 16'h0000;
            rmd_q <= 16'h0000;
            dvd_q <= 32'h0000_0000;
        end else if (clk_en_in) begin
            done_q <= 1'b0;
            if (dv.start) begin
                busy_q <= 1'b1;
                cnt_q <= 5'h00;
                part_q <= mag[31:16];
                shf_q <= mag[15:0];
                dvs_q <= dmag;
                sgn_q <= dv.sgn;
                dvd_q <= dv.dividend;
                negq_q <= dv.sgn && (dv.dividend[31] ^ dv.divisor[15]);
                negr_q <= dv.sgn && dv.dividend[31];
                // Zero divisor also lands here
                ovf_q <= mag[31:16] >= dmag; // RQ9
            end else if (busy_q && !dv.hold) begin
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q < DIV_STEPS) begin
                    shf_q <= {shf_q[14:0], !diff[16]}; // RQ12
                    part_q <= diff[16] ? trial[15:0] : diff[15:0]; // RQ12
                end else if (cnt_q == DIV_STEPS) begin
                    quot_q <= negq_q ? -shf_q : shf_q; // RQ9
                    rmd_q <= negr_q ? -part_q : part_q;
                    if (negq_q ? (shf_q > SIGN16) : (sgn_q && shf_q[15])) begin
                        ovf_q <= 1'b1;
                    end
                end else if (cnt_q == DIV_LAST) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign dv.busy = busy_q;
    assign dv.done = done_q;
    assign dv.ovf = ovf_q;
    assign dv.quot = quot_q;
    assign dv.rmd = rmd_q;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_div_exact: assert property ( // RQ9
        done_q && !ovf_q && !sgn_q |->
        (32'(quot_q) * 32'(dvs_q) + 32'(rmd_q) == dvd_q) && (rmd_q < dvs_q))
        else $error("unsigned quotient and remainder do not rebuild dividend");
endmodule
`default_nettype wire

/* cpalu_top.sv */
// Core ALU: add, logic, shifts, multiply and iterative divide
//
// How it works
// [RQ1] 16-bit ALU doing add, subtract, shifts and bitwise logic.
// [RQ2] Arithmetic is two's complement unless the operation is unsigned.
// [RQ3] Each operation updates only its own flags; others keep their value.
// [RQ4] Subtract uses carry as inverted borrow, digit carry as inverted digit borrow.
// [RQ5] Byte or word width chosen per instruction.
// [RQ6] Operand and result go to working registers or memory per decoder select.
// [RQ7] One 17 by 17 multiplier; sign or zero extension covers both signs.
// [RQ8] Multiply modes: SS, UU, US, word by 5-bit literal, byte UU.
// [RQ9] Divide 32/16 and 16/16, signed and unsigned.
// [RQ10] Divide ends with quotient to register zero, remainder to register one.
// [RQ11] Divisor any register; 32-bit dividend from even/odd register pair.
// [RQ12] One quotient bit per cycle, same length for both dividend sizes.
// [RQ13] Single-bit and multibit shifts, multibit done in one cycle.
// [RQ14] Arithmetic right or left shift by up to 15 bits in one cycle.
// [RQ15] Multibit shifts only from and to working registers.
// [RQ16] Shifts: sign-fill right, zero-fill left, zero-fill right.
// [RQ17] Digit carry from bit 3 in byte mode, bit 7 in word mode.
// [RQ18] Overflow flag marks signed overflow of the result width.
// [RQ19] Carry flag marks carry out of the result's top bit.
// [RQ20] Every divide takes 19 cycles and may pause at any cycle boundary.
// [RQ21] Negative flag is result top bit; zero flag marks an all-zero result.
`default_nettype none
module cpalu_top import cpalu_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic op_valid_in,
    input wire cpalu_op_t op_in,
    input wire logic byte_in,
    input wire logic src_mem_in,
    input wire logic dest_mem_in,
    input wire logic [15:0] wreg_a_in,
    input wire logic [15:0] wreg_b_in,
    input wire logic [15:0] mem_in,
    input wire logic [15:0] pair_hi_in,
    input wire logic [4:0] lit_in,
    input wire logic div_hold_in,
    input wire logic [3:0] bus_addr_in,
    input wire logic [15:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [15:0] bus_rdata_out,
    output logic [15:0] result_out,
    output logic [15:0] result_hi_out,
    output logic byte_out,
    output logic wreg_wr_en_out,
    output logic mem_wr_en_out,
    output logic refused_out,
    output logic busy_out,
    output logic quot_wr_en_out,
    output logic [15:0] quot_out,
    output logic rem_wr_en_out,
    output logic [15:0] rem_out,
    output logic [15:0] status_out
);
    cpalu_div_if dv ();

    logic [15:0] status_q, st_d, opb, bx, shx, res_d, hi_d, flg_d, upd_d, dflg;
    logic cin, sub_op, is_mul, is_div, is_shift, multi, accept;
    logic eff_byte, refuse_d, wr_d, sticky, zero;
    logic [4:0] nib5;
    logic [8:0] lo9;
    logic [16:0] s17, sl17, rt17;
    logic signed [16:0] ma, mb;
    logic signed [33:0] prod;
    logic upd_q, sticky_q;
    logic [4:0] div_age_q;

    // ==========================================================
    // Operand selection and decode
    assign opb = src_mem_in ? mem_in : wreg_b_in; // RQ6
    assign is_mul = op_in inside {OP_MUL_SS, OP_MUL_UU, OP_MUL_US,
                                  OP_MUL_SL, OP_MUL_UL, OP_MUL_BB};
    assign is_div = op_in inside {OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16};
    assign is_shift = op_in inside {OP_SHL, OP_SAR, OP_SHR};
    assign multi = lit_in[3:0] != SHIFT_ONE;
    assign eff_byte = (byte_in && !is_mul && !is_div) || op_in == OP_MUL_BB; // RQ5
    // A busy divider owns the flags and the result registers
    assign accept = op_valid_in && !busy_out;
    assign sticky = op_in inside {OP_ADDC, OP_SUBB};

    // ==========================================================
    // Adder with byte and nibble carries
    assign sub_op = op_in inside {OP_SUB, OP_SUBB};
    assign bx = sub_op ? ~opb : opb; // RQ4
    assign cin = sticky ? status_q[FLG_C] : sub_op; // RQ4
    assign nib5 = 5'(wreg_a_in[3:0]) + 5'(bx[3:0]) + 5'(cin); // RQ17
    assign lo9 = 9'(wreg_a_in[7:0]) + 9'(bx[7:0]) + 9'(cin); // RQ1
    assign s17 = 17'(wreg_a_in) + 17'(bx) + 17'(cin); // RQ1 RQ2

    // ==========================================================
    // Barrel shifter, the source is the selected operand
    always_comb begin
        shx = opb;
        if (eff_byte) begin
            shx = (op_in == OP_SAR) ? {{8{opb[7]}}, opb[7:0]} : {8'h00, opb[7:0]};
        end
    end
    assign sl17 = 17'(shx) << lit_in[3:0]; // RQ13 RQ14 RQ16
    assign rt17 = (op_in == OP_SAR) ? 17'($signed({shx, 1'b0}) >>> lit_in[3:0])
                                    : ({shx, 1'b0} >> lit_in[3:0]); // RQ13 RQ14 RQ16

    // ==========================================================
    // Multiplier, every mode widened to 17 bits
    always_comb begin
        ma = $signed({1'b0, wreg_a_in});
        mb = $signed({1'b0, opb});
        unique case (op_in)
            OP_MUL_SS: begin
                ma = $signed({wreg_a_in[15], wreg_a_in}); // RQ8
                mb = $signed({opb[15], opb});
            end
            OP_MUL_US: mb = $signed({opb[15], opb}); // RQ8
            OP_MUL_SL: begin
                ma = $signed({wreg_a_in[15], wreg_a_in}); // RQ8
                mb = $signed({12'h000, lit_in});
            end
            OP_MUL_UL: mb = $signed({12'h000, lit_in}); // RQ8
            OP_MUL_BB: begin
                ma = $signed({9'h000, wreg_a_in[7:0]}); // RQ8
                mb = $signed({9'h000, opb[7:0]});
            end
            default: ;
        endcase
    end
    assign prod = ma * mb; // RQ7

    // ==========================================================
    // Result and flag selection
    always_comb begin
        res_d = 16'h0000;
        hi_d = 16'h0000;
        flg_d = status_q;
        upd_d = 16'h0000;
        refuse_d = 1'b0;
        wr_d = 1'b1;
        zero = 1'b0;
        unique case (op_in)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
                upd_d = UPD_ARITH; // RQ3
                if (eff_byte) begin
                    res_d = {8'h00, lo9[7:0]};
                    flg_d[FLG_C] = lo9[8]; // RQ19
                    flg_d[FLG_DCY] = nib5[4]; // RQ17
                    flg_d[FLG_OVF] = (wreg_a_in[7] == bx[7]) && (lo9[7] != wreg_a_in[7]); // RQ18
                end else begin
                    res_d = s17[15:0];
                    flg_d[FLG_C] = s17[16]; // RQ19
                    flg_d[FLG_DCY] = lo9[8]; // RQ17
                    flg_d[FLG_OVF] = (wreg_a_in[15] == bx[15]) && (s17[15] != wreg_a_in[15]); // RQ18
                end
            end
            OP_AND: begin
                res_d = wreg_a_in & opb; // RQ1
                upd_d = UPD_LOGIC;
            end
            OP_IOR: begin
                res_d = wreg_a_in | opb;
                upd_d = UPD_LOGIC;
            end
            OP_XOR: begin
                res_d = wreg_a_in ^ opb;
                upd_d = UPD_LOGIC;
            end
            OP_SHL, OP_SAR, OP_SHR: begin
                res_d = (op_in == OP_SHL) ? sl17[15:0] : rt17[16:1];
                if (op_in == OP_SHL) begin
                    flg_d[FLG_C] = eff_byte ? sl17[8] : sl17[16];
                end else begin
                    flg_d[FLG_C] = rt17[0];
                end
                // A zero-length shift has no last bit out, so carry stays
                upd_d = (lit_in[3:0] == 4'h0) ? UPD_LOGIC : UPD_SHIFT; // RQ3
                refuse_d = multi && (src_mem_in || dest_mem_in); // RQ15
            end
            OP_MUL_SS, OP_MUL_UU, OP_MUL_US, OP_MUL_SL, OP_MUL_UL, OP_MUL_BB: begin
                res_d = prod[15:0]; // RQ7
                hi_d = prod[31:16];
            end
            OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16: wr_d = 1'b0;
            default: refuse_d = 1'b1;
        endcase
        if (eff_byte && op_in != OP_MUL_BB) begin
            res_d[15:8] = 8'h00; // RQ5
        end
        zero = eff_byte ? (res_d[7:0] == 8'h00) : (res_d == 16'h0000);
        flg_d[FLG_N] = eff_byte ? res_d[7] : res_d[15]; // RQ21
        // Carry chains only clear zero, so multiword results test whole
        flg_d[FLG_Z] = sticky ? (status_q[FLG_Z] && zero) : zero; // RQ21
    end

    // ==========================================================
    // Divider hookup
    assign dv.start = accept && is_div; // RQ9
    assign dv.hold = div_hold_in; // RQ20
    assign dv.sgn = op_in inside {OP_DIV_S32, OP_DIV_S16}; // RQ2
    assign dv.divisor = wreg_b_in; // RQ11
    always_comb begin
        unique case (op_in)
            OP_DIV_S32, OP_DIV_U32: dv.dividend = {pair_hi_in, wreg_a_in}; // RQ11
            OP_DIV_S16: dv.dividend = {{16{wreg_a_in[15]}}, wreg_a_in};
            default: dv.dividend = {16'h0000, wreg_a_in};
        endcase
    end
    assign busy_out = dv.busy;

    cpalu_div u_div (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .dv(dv.eng)
    );

    always_comb begin
        dflg = 16'h0000;
        dflg[FLG_Z] = dv.quot == 16'h0000;
        dflg[FLG_N] = dv.quot[15];
        dflg[FLG_OVF] = dv.ovf;
    end

    // ==========================================================
    // Status word: hardware beats a software write in the same cycle
    always_comb begin
        st_d = status_q;
        if (bus_wr_in && bus_addr_in == OFS_STATUS) begin
            st_d = bus_wdata_in & STATUS_WMASK;
        end
        if (dv.done) begin
            st_d = (st_d & ~UPD_DIV) | (dflg & UPD_DIV); // RQ3
        end
        if (accept && !refuse_d) begin
            st_d = (st_d & ~upd_d) | (flg_d & upd_d); // RQ3
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_q <= STATUS_RST;
        end else if (clk_en_in) begin
            status_q <= st_d;
        end
    end
    assign status_out = status_q;

    // ==========================================================
    // Result path
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_out <= 16'h0000;
            result_hi_out <= 16'h0000;
            byte_out <= 1'b0;
            wreg_wr_en_out <= 1'b0;
            mem_wr_en_out <= 1'b0;
            refused_out <= 1'b0;
            upd_q <= 1'b0;
            sticky_q <= 1'b0;
        end else if (clk_en_in) begin
            wreg_wr_en_out <= accept && wr_d && !refuse_d && !dest_mem_in; // RQ6
            mem_wr_en_out <= accept && wr_d && !refuse_d && dest_mem_in; // RQ6
            refused_out <= op_valid_in && (busy_out || refuse_d); // RQ15
            upd_q <= accept && !refuse_d && upd_d[FLG_N];
            sticky_q <= sticky;
            if (accept && wr_d && !refuse_d) begin
                result_out <= res_d;
                result_hi_out <= hi_d;
                byte_out <= eff_byte;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            quot_wr_en_out <= 1'b0;
            rem_wr_en_out <= 1'b0;
            quot_out <= 16'h0000;
            rem_out <= 16'h0000;
        end else if (clk_en_in) begin
            quot_wr_en_out <= dv.done; // RQ10
            rem_wr_en_out <= dv.done; // RQ10
            if (dv.done) begin
                quot_out <= dv.quot; // RQ10
                rem_out <= dv.rmd; // RQ10
            end
        end
    end

    // ==========================================================
    // Register read port
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_rdata_out <= 16'h0000;
        end else if (clk_en_in) begin
            bus_rdata_out <= 16'h0000;
            if (bus_rd_in && bus_addr_in == OFS_STATUS) begin
                bus_rdata_out <= status_q;
            end else if (bus_rd_in && bus_addr_in == OFS_DIVSTAT) begin
                bus_rdata_out <= {14'h0000, div_hold_in, dv.busy};
            end
        end
    end

    // ==========================================================
    // Checks
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_age_q <= 5'h00;
        end else if (clk_en_in) begin
            if (dv.start) begin
                div_age_q <= 5'h00;
            end else if ((dv.busy && !div_hold_in) || dv.done) begin
                div_age_q <= div_age_q + 5'h01;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_mul_flags_kept: assert property ( // RQ3
        clk_en_in && accept && is_mul && !dv.done && !bus_wr_in |=> $stable(status_q))
        else $error("multiply changed the status word");
    chk_mul_signed: assert property ( // RQ8
        clk_en_in && accept && op_in == OP_MUL_SS |=>
        {result_hi_out, result_out} == 32'($signed($past(wreg_a_in)) * $signed($past(opb))))
        else $error("signed multiply product wrong");
    chk_sub_borrow: assert property ( // RQ4
        clk_en_in && accept && op_in == OP_SUB && !eff_byte && wreg_a_in >= opb
        |=> status_q[FLG_C])
        else $error("subtract without borrow left carry clear");
    chk_byte_width: assert property ( // RQ5
        (wreg_wr_en_out || mem_wr_en_out) && byte_out && !$past(op_in == OP_MUL_BB)
        |-> result_out[15:8] == 8'h00)
        else $error("byte result has upper bits set");
    chk_neg_zero: assert property ( // RQ21
        (wreg_wr_en_out || mem_wr_en_out) && upd_q |->
        status_q[FLG_N] == (byte_out ? result_out[7] : result_out[15]) &&
        (sticky_q || status_q[FLG_Z] == (byte_out ? result_out[7:0] == 8'h00
                                                  : result_out == 16'h0000)))
        else $error("negative or zero flag disagrees with result");
    chk_shift_refused: assert property ( // RQ15
        clk_en_in && accept && is_shift && multi && (dest_mem_in || src_mem_in)
        |=> refused_out && !mem_wr_en_out && !wreg_wr_en_out)
        else $error("multibit shift with memory operand was not refused");
    chk_shift_left: assert property ( // RQ14
        clk_en_in && accept && op_in == OP_SHL && !eff_byte && !refuse_d
        |=> result_out == ($past(opb) << $past(lit_in[3:0])))
        else $error("left shift result wrong");
    chk_div_latency: assert property ( // RQ20
        $rose(quot_wr_en_out) |-> div_age_q == DIV_CYCLES)
        else $error("divide did not take the fixed cycle count");
    chk_div_pair: assert property ( // RQ10
        quot_wr_en_out |-> rem_wr_en_out && quot_out == $past(dv.quot) ##1 !quot_wr_en_out [*2])
        else $error("quotient and remainder writes not paired");

    cov_div_done: cover property (quot_wr_en_out);
    cov_refused: cover property (refused_out);
    cov_byte_add: cover property (clk_en_in && accept && op_in == OP_ADD && eff_byte);
    cov_mul_mixed: cover property (clk_en_in && accept && op_in == OP_MUL_US);
endmodule
`default_nettype wire

/* cpalu_wreg_model.sv */
// Behavioural working register file that takes the divide results
`default_nettype none
module cpalu_wreg_model (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic quot_wr_en_in,
    input wire logic [15:0] quot_in,
    input wire logic rem_wr_en_in,
    input wire logic [15:0] rem_in,
    output logic [15:0] w0_out,
    output logic [15:0] w1_out
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            w0_out <= 16'h0000;
            w1_out <= 16'h0000;
        end else begin
            if (quot_wr_en_in) w0_out <= quot_in;
            if (rem_wr_en_in) w1_out <= rem_in;
        end
    end
endmodule
`default_nettype wire

/* test_cpu_alu_mul_div_shift.sv */
// Self-checking bench of the core ALU with a register file model
`default_nettype none
module test_cpu_alu_mul_div_shift import cpalu_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, vld = 0, bt = 0, sm = 0, dm = 0, hold = 0, wr = 0, rd = 0, ce = 1;
    cpalu_op_t op = OP_ADD;
    cpalu_op_t ops[4] = '{OP_AND, OP_SHL, OP_SAR, OP_SHR};
    cpalu_op_t mops[4] = '{OP_MUL_UU, OP_MUL_SS, OP_MUL_UL, OP_MUL_BB};
    logic [15:0] a = 0, b = 0, mb = 0, hi = 0, wd = 0, rnd = 16'h5bca, es = 0;
    logic [15:0] rdat, res, rhi, quo, rem, st, w0, w1;
    logic [4:0] lit = 0;
    logic [3:0] ad = 0;
    logic bo, wwe, mwe, rf, bsy, qwe, rwe;
    int mismatches = 0, n_checks = 0, cycles = 0;
    cpalu_top cpalu_top_i (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(ce),
        .op_valid_in(vld), .op_in(op), .byte_in(bt), .src_mem_in(sm), .dest_mem_in(dm),
        .wreg_a_in(a), .wreg_b_in(b), .mem_in(mb), .pair_hi_in(hi), .lit_in(lit),
        .div_hold_in(hold), .bus_addr_in(ad), .bus_wdata_in(wd), .bus_wr_in(wr),
        .bus_rd_in(rd), .bus_rdata_out(rdat), .result_out(res), .result_hi_out(rhi),
        .byte_out(bo), .wreg_wr_en_out(wwe), .mem_wr_en_out(mwe), .refused_out(rf),
        .busy_out(bsy), .quot_wr_en_out(qwe), .quot_out(quo), .rem_wr_en_out(rwe),
        .rem_out(rem), .status_out(st));
    cpalu_wreg_model cpalu_wreg_model_i (.sys_clk_in(clk), .rst_n_in(rst_n),
        .quot_wr_en_in(qwe), .quot_in(quo), .rem_wr_en_in(rwe), .rem_in(rem),
        .w0_out(w0), .w1_out(w1));
    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd;
    endfunction
    function automatic logic [15:0] zn(input logic [15:0] r);
        return {12'h000, r[15], 1'b0, r == 16'h0000, 1'b0};
    endfunction
    function automatic logic [31:0] addx(input logic [15:0] x, y, input logic s);
        logic [16:0] t;
        logic [8:0] d;
        logic [15:0] v;
        v = s ? ~y : y;
        t = x + v + s;
        d = x[7:0] + v[7:0] + s;
        return {7'h00, d[8], 4'h0, t[15], (x[15] == v[15]) && (t[15] != x[15]),
                t[15:0] == 16'h0000, t[16], t[15:0]};
    endfunction
    function automatic logic [31:0] shx(input cpalu_op_t o, input logic [15:0] x, y,
                                        input logic [3:0] k);
        logic [15:0] r;
        logic [15:0] f;
        r = x & y;
        f = (es & ~UPD_LOGIC) | zn(r);
        if (o != OP_AND) begin
            case (o)
                OP_SHL: r = y << k;
                OP_SAR: r = $signed(y) >>> k;
                default: r = y >> k;
            endcase
            f = (es & ~UPD_SHIFT) | zn(r);
            f[FLG_C] = (k == 4'h0) ? es[FLG_C] : (o == OP_SHL) ? y[16 - k] : y[k - 1];
        end
        return {f, r};
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Memory mode puts the real operand on mem_in and junk on the register side
    task automatic go(input cpalu_op_t o, input logic [15:0] x, y, input logic w, m,
                      input logic [4:0] l);
        @(posedge clk);
        vld <= 1;
        op <= o;
        a <= x;
        b <= m ? ~y : y;
        mb <= m ? y : ~y;
        bt <= w;
        sm <= m;
        dm <= m;
        lit <= l;
        hi <= lfsr();
        @(posedge clk);
        vld <= 0;
        #1;
    endtask
    task automatic rdreg(input logic [3:0] x, input logic [15:0] e);
        @(posedge clk);
        rd <= 1;
        ad <= x;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdat, e);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        logic [47:0] e;
        logic [15:0] x, y;
        logic [3:0] k;
        logic m;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        rdreg(OFS_STATUS, STATUS_RST);
        @(posedge clk);
        wr <= 1;
        ad <= OFS_STATUS;
        wd <= 16'hffff;
        @(posedge clk);
        wr <= 0;
        rdreg(OFS_STATUS, STATUS_WMASK);
        rdreg(4'h5, 16'h0000);
        go(OP_ADD, 16'h127f, 16'h3401, 1'b1, 1'b0, 5'h00);
        chk({bo, res, st}, {1'b1, 16'h0080, 16'h010c});
        es = 16'h010c;
        for (int i = 0; i < 40; i++) begin
            x = (i == 0) ? 16'h0000 : (i == 1) ? 16'h7fff : lfsr();
            y = (i < 2) ? 16'h0001 : lfsr();
            m = y[1];
            e = addx(x, y, i != 1 && x[0]);
            go((i != 1 && x[0]) ? OP_SUB : OP_ADD, x, y, 1'b0, m, 5'h00);
            es = e[31:16];
            chk({res, st, wwe, mwe}, {e[15:0], es, !m, m});
        end
        for (int i = 0; i < 32; i++) begin
            x = lfsr();
            y = lfsr();
            k = (i < 4) ? 4'h0 : (i < 8) ? 4'hf : (i < 12) ? SHIFT_ONE : x[3:0];
            m = (k == SHIFT_ONE);
            e = shx(ops[i % 4], x, y, k);
            go(ops[i % 4], x, y, 1'b0, m, {1'b0, k});
            es = e[31:16];
            chk({res, st, wwe, mwe}, {e[15:0], es, !m, m});
        end
        go(OP_SHR, x, y, 1'b0, 1'b1, 5'h03);
        chk({rf, wwe, mwe, st}, {3'b100, es});
        for (int i = 0; i < 16; i++) begin
            x = lfsr();
            y = lfsr();
            case (i % 4)
                0: e = x * y;
                1: e = 48'($signed(x) * $signed(y));
                2: e = x * y[4:0];
                default: e = x[7:0] * y[7:0];
            endcase
            go(mops[i % 4], x, y, 1'b0, 1'b0, y[4:0]);
            chk({rhi, res, st}, {e[31:0], es});
        end
        for (int h = 0; h < 2; h++) begin
            x = (h == 1) ? 16'h0003 : lfsr();
            y = (lfsr() >> 4) | 16'h0011;
            go(OP_DIV_U16, x, y, 1'b0, 1'b0, 5'h00);
            @(posedge clk);
            vld <= 1;
            op <= OP_ADD;
            hold <= h[0];
            @(posedge clk);
            vld <= 0;
            hold <= 0;
            ce <= !h[0];
            #1 chk({rf, bsy}, 2'b11);
            @(posedge clk) ce <= 1;
            repeat (15 + 2 * h) @(posedge clk);
            #1 chk(qwe, 1'b0);
            @(posedge clk);
            #1 chk({qwe, rwe, quo, rem}, {2'b11, x / y, x % y});
            es = (es & ~UPD_DIV) | zn(x / y);
            chk(st, es);
            @(posedge clk);
            #1 chk({w0, w1}, {x / y, x % y});
        end
        rdreg(OFS_DIVSTAT, 16'h0000);
        rdreg(OFS_STATUS, es);
        end_of_test();
    end
endmodule
`default_nettype wire
